/* hw/dcs_pkg.sv */
// Constants for the dual-channel switch: register map, status bytes, command codes.
// Assumes an AXI4-Lite master with 32-bit data; byte addresses below.
package dcs_pkg;
	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] DCS_OFF_CTRL   = 8'h00; // [7:0] unit address
	localparam logic [7:0] DCS_OFF_CMD    = 8'h04; // wr: [7:0] command, [8] chained
	localparam logic [7:0] DCS_OFF_EVT    = 8'h08; // wr: events; rd: switch status
	localparam logic [7:0] DCS_OFF_FLAGS  = 8'h0c; // rd: primary flag word
	localparam logic [7:0] DCS_OFF_TAGS   = 8'h10; // rd: tags-in shadow
	localparam logic [7:0] DCS_OFF_SENSE  = 8'h14; // rd: count of sense executions
	// ---------------------------------------------------------------
	// Event write bits (DCS_OFF_EVT) and the chain bit of DCS_OFF_CMD
	// ---------------------------------------------------------------
	localparam int DCS_EVT_END_CHAIN = 0;
	localparam int DCS_EVT_STACK_CHK = 1;
	localparam int DCS_EVT_DEV_END   = 2;
	localparam int DCS_EVT_CLR_DE_A  = 3;
	localparam int DCS_EVT_CLR_DE_B  = 4;
	localparam int DCS_EVT_CLR_REJ   = 5;
	localparam int DCS_CMD_CHAIN_BIT = 8;
	// ---------------------------------------------------------------
	// Bytes and codes; bit 0 is the most significant bit of a byte
	// ---------------------------------------------------------------
	localparam logic [7:0] DCS_CMD_RESERVE   = 8'hf4;
	localparam logic [7:0] DCS_CMD_RELEASE   = 8'hd4;
	localparam logic [7:0] DCS_CMD_MOD_MASK  = 8'h20; // modifier bit 2
	localparam logic [7:0] DCS_STAT_BUSY     = 8'h50; // bits 1 and 3
	localparam logic [7:0] DCS_STAT_CUE      = 8'h20; // bit 2
	localparam logic [7:0] DCS_RESV_FLAG     = 8'h20; // reserve flag in flag word
	localparam logic [7:0] DCS_TAGS_HOLD     = 8'h20; // tags-in position 2
	localparam logic [7:0] DCS_UNIT_ADDR_RST = 8'h00;
	localparam logic [1:0] DCS_RESP_OKAY     = 2'b00;
	localparam logic [1:0] DCS_RESP_SLVERR   = 2'b10;
	typedef enum logic [2:0] {
		DCS_SW_IDLE = 3'b001,
		DCS_SW_A    = 3'b010,
		DCS_SW_B    = 3'b100
	} dcs_sw_t;
endpackage : dcs_pkg

/* hw/dcs_switch.sv */
// Dual-channel interface switch: connects the common control logic to channel A or B.
// Assumes both channel interfaces and the register bus are synchronous to CLK.
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module dcs_switch
	import dcs_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic [7:0]  CHA_BUS_OUT,
	input  wire logic        CHA_ADDR_OUT,
	input  wire logic        CHA_SELECT,
	input  wire logic        CHA_RESET,
	input  wire logic        CHA_STAT_ACK,
	input  wire logic [7:0]  CHB_BUS_OUT,
	input  wire logic        CHB_ADDR_OUT,
	input  wire logic        CHB_SELECT,
	input  wire logic        CHB_RESET,
	input  wire logic        CHB_STAT_ACK,
	output logic             CHA_OP_IN,
	output logic             CHA_DRV_EN,
	output logic             CHA_STATUS_IN,
	output logic             CHA_REQ_IN,
	output logic [7:0]       CHA_BUS_IN,
	output logic             CHA_BUS_IN_P,
	output logic             CHB_OP_IN,
	output logic             CHB_DRV_EN,
	output logic             CHB_STATUS_IN,
	output logic             CHB_REQ_IN,
	output logic [7:0]       CHB_BUS_IN,
	output logic             CHB_BUS_IN_P,
	output logic             INIT_SEL,
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY
);
	// ---------------------------------------------------------------
	// Channel decode
	// ---------------------------------------------------------------
	dcs_sw_t     sw_q, sw_d;
	logic [7:0]  unit_addr_q;
	logic [1:0]  sel_out_q, sel_dly_q, cue_q, cue_d, op_in_q, op_in_d;
	logic [1:0]  stin_q, reqin_q, reqin_d, de_pend_q, drv_q;
	logic [7:0]  bus_in_q [2];
	logic [1:0]  par_q;
	logic        resv_q, resv_d, resv_ch_q, resv_ch_d, hold_q, hold_d, origin_q, rej_q;
	logic [7:0]  flags_q, flags_d, tags_q, tags_d;
	logic [7:0]  sense_cnt_q;
	logic        init_q;
	wire  [15:0] bus_out      = {CHB_BUS_OUT, CHA_BUS_OUT};
	wire  [1:0]  addr_out     = {CHB_ADDR_OUT, CHA_ADDR_OUT};
	wire  [1:0]  select       = {CHB_SELECT, CHA_SELECT};
	wire  [1:0]  ch_reset     = {CHB_RESET, CHA_RESET};
	wire  [1:0]  stat_ack     = {CHB_STAT_ACK, CHA_STAT_ACK};
	wire  [1:0]  own          = {sw_q == DCS_SW_B, sw_q == DCS_SW_A};
	wire  [1:0]  own_d        = {sw_d == DCS_SW_B, sw_d == DCS_SW_A};
	wire  [1:0]  match, claim, other_busy, busy_hit, reset_ok, cue_go;
	wire         neutral      = (sw_q == DCS_SW_IDLE);
	wire         owner_ch     = own[1];

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ch
			assign match[gi]      = addr_out[gi] && (bus_out[gi*8 +: 8] == unit_addr_q);
			assign claim[gi]      = ~sel_out_q[gi] & ~cue_q[gi];
			assign other_busy[gi] = own[1-gi] | (resv_q & (resv_ch_q != gi));
			// First cycle of a match, seen while the select latch is still set
			assign busy_hit[gi]   = match[gi] & sel_out_q[gi] & other_busy[gi];
			assign reset_ok[gi]   = ch_reset[gi] & (own[gi] | (resv_q & resv_ch_q == gi));
			assign cue_go[gi]     = own[gi] & cue_q[gi] & ~op_in_q[gi] & ~reqin_q[gi];
		end
	endgenerate

	// ---------------------------------------------------------------
	// Register bus decode
	// ---------------------------------------------------------------
	logic        awready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0]  bresp_q, rresp_q;
	logic [31:0] rdata_q, wdata_q;
	logic [7:0]  waddr_q;
	wire         wr_go   = S_AXI_AWVALID & S_AXI_WVALID & ~awready_q & ~bvalid_q;
	wire         rd_go   = S_AXI_ARVALID & ~arready_q & ~rvalid_q;
	logic [3:0]  wstrb_q;
	// Only the low byte lane strobe gates a write, though the chain bit sits in lane 1; a write without it is acknowledged and dropped
	wire         wr_do   = awready_q & wstrb_q[0];
	wire         wr_ctrl = wr_do & (waddr_q == DCS_OFF_CTRL);
	wire         wr_cmd  = wr_do & (waddr_q == DCS_OFF_CMD);
	wire         wr_evt  = wr_do & (waddr_q == DCS_OFF_EVT);
	wire         wr_map  = (waddr_q == DCS_OFF_CTRL) | (waddr_q == DCS_OFF_CMD) | (waddr_q == DCS_OFF_EVT);
	wire [7:0]   cmd     = wdata_q[7:0];
	wire         cmd_rr  = wr_cmd & ((cmd & ~DCS_CMD_MOD_MASK) == DCS_CMD_RELEASE) & ~neutral & |op_in_q;
	wire         chained = wdata_q[DCS_CMD_CHAIN_BIT];
	wire         is_resv = |(cmd & DCS_CMD_MOD_MASK);
	wire         end_chain = wr_evt & wdata_q[DCS_EVT_END_CHAIN];
	wire [31:0]  status_word = {18'h00000, sense_cnt_q[0], rej_q, hold_q, resv_ch_q, resv_q,
	                            de_pend_q, cue_q, op_in_q, sw_q};
	wire [31:0]  rd_mux =
		(S_AXI_ARADDR == DCS_OFF_CTRL)  ? {24'h000000, unit_addr_q} :
		(S_AXI_ARADDR == DCS_OFF_EVT)   ? status_word :
		(S_AXI_ARADDR == DCS_OFF_FLAGS) ? {24'h000000, flags_q} :
		(S_AXI_ARADDR == DCS_OFF_TAGS)  ? {24'h000000, tags_q} :
		(S_AXI_ARADDR == DCS_OFF_SENSE) ? {24'h000000, sense_cnt_q} : 32'h00000000;
	wire         rd_map  = (S_AXI_ARADDR == DCS_OFF_CTRL) | (S_AXI_ARADDR == DCS_OFF_EVT) |
	                       (S_AXI_ARADDR == DCS_OFF_FLAGS) | (S_AXI_ARADDR == DCS_OFF_TAGS) |
	                       (S_AXI_ARADDR == DCS_OFF_SENSE);

	// ---------------------------------------------------------------
	// Switch next state
	// ---------------------------------------------------------------
	always_comb begin
		sw_d      = sw_q;
		op_in_d   = op_in_q;
		cue_d     = cue_q | busy_hit;
		reqin_d   = reqin_q;
		resv_d    = resv_q;
		resv_ch_d = resv_ch_q;
		hold_d    = hold_q;
		flags_d   = flags_q;
		tags_d    = tags_q;
		// A foreign reset is ignored outright, so it cannot touch the other side's state
		if (|reset_ok) begin
			sw_d    = DCS_SW_IDLE;
			op_in_d = op_in_q & ~reset_ok;
			reqin_d = reqin_q & ~reset_ok;
			resv_d  = 1'b0;
			hold_d  = 1'b0;
			flags_d = flags_q & ~DCS_RESV_FLAG;
			tags_d  = tags_q & ~DCS_TAGS_HOLD;
		end else begin
			case (sw_q)
				DCS_SW_IDLE: begin
					// Port A wins a simultaneous claim; B keeps its claim for later
					if (claim[0] & select[0] & ~other_busy[0])
						sw_d = DCS_SW_A;
					else if (claim[1] & select[1] & ~other_busy[1])
						sw_d = DCS_SW_B;
					else if (cue_q[0] & ~other_busy[0])
						sw_d = DCS_SW_A;
					else if (cue_q[1] & ~other_busy[1])
						sw_d = DCS_SW_B;
				end
				DCS_SW_A, DCS_SW_B: begin
					if (own[owner_ch] & sel_dly_q[owner_ch] & ~op_in_q[owner_ch] & ~cue_q[owner_ch])
						op_in_d[owner_ch] = 1'b1;
					if (cue_go[owner_ch])
						reqin_d[owner_ch] = 1'b1;
					if (reqin_q[owner_ch] & stat_ack[owner_ch]) begin
						reqin_d[owner_ch] = 1'b0;
						cue_d[owner_ch]   = busy_hit[owner_ch];
					end
					if (end_chain)
						op_in_d[owner_ch] = 1'b0;
					if (wr_evt & wdata_q[DCS_EVT_STACK_CHK])
						hold_d = 1'b1;
					else if (stat_ack[owner_ch])
						hold_d = 1'b0;
					if (cmd_rr & ~chained) begin
						resv_d    = is_resv;
						resv_ch_d = owner_ch;
						flags_d   = is_resv ? (flags_q | DCS_RESV_FLAG) : (flags_q & ~DCS_RESV_FLAG);
						tags_d    = is_resv ? (tags_q | DCS_TAGS_HOLD) : (tags_q & ~DCS_TAGS_HOLD);
					end
					// Tags-in position 2 keeps the owner latch through the end of a chain
					if (~op_in_d[owner_ch] & ~hold_d & ~|(tags_d & DCS_TAGS_HOLD) & ~reqin_d[owner_ch] &
					    ~cue_d[owner_ch] & ~select[owner_ch])
						sw_d = DCS_SW_IDLE;
				end
				default: sw_d = DCS_SW_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Switch registers
	// ---------------------------------------------------------------
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sw_q      <= DCS_SW_IDLE;
			op_in_q   <= 2'b00;
			cue_q     <= 2'b00;
			reqin_q   <= 2'b00;
			resv_q    <= 1'b0;
			resv_ch_q <= 1'b0;
			hold_q    <= 1'b0;
			flags_q   <= 8'h00;
			tags_q    <= 8'h00;
			drv_q     <= 2'b00;
			init_q    <= 1'b0;
			origin_q  <= 1'b0;
		end else begin
			sw_q      <= sw_d;
			op_in_q   <= op_in_d;
			cue_q     <= cue_d;
			reqin_q   <= reqin_d;
			resv_q    <= resv_d;
			resv_ch_q <= resv_ch_d;
			hold_q    <= hold_d;
			flags_q   <= flags_d;
			tags_q    <= tags_d;
			drv_q     <= (op_in_d | reqin_d) & own_d;
			init_q    <= |(op_in_d & ~op_in_q);
			if (|(op_in_d & ~op_in_q))
				origin_q <= op_in_d[1];
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sel_out_q <= 2'b11;
			sel_dly_q <= 2'b00;
		end else begin
			sel_dly_q <= select;
			for (int i = 0; i < 2; i++) begin
				if (match[i])
					sel_out_q[i] <= 1'b0;
				else if (~select[i] & ~addr_out[i] & ~op_in_q[i])
					sel_out_q[i] <= 1'b1;
			end
		end
	end

	// Status bytes toward the channels; short busy pulses status-in for one cycle with the busy byte
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			stin_q      <= 2'b00;
			par_q       <= 2'b00;
			bus_in_q[0] <= 8'h00;
			bus_in_q[1] <= 8'h00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				stin_q[i] <= busy_hit[i];
				if (busy_hit[i]) begin
					bus_in_q[i] <= DCS_STAT_BUSY;
					par_q[i]    <= ~^DCS_STAT_BUSY;
				end else if (reqin_d[i]) begin
					bus_in_q[i] <= DCS_STAT_CUE;
					par_q[i]    <= ~^DCS_STAT_CUE;
				end else begin
					bus_in_q[i] <= 8'h00;
					par_q[i]    <= 1'b1;
				end
			end
		end
	end

	// Device end, sense count and command reject; a set wins over a same-cycle clear
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			de_pend_q   <= 2'b00;
			rej_q       <= 1'b0;
			sense_cnt_q <= 8'h00;
			unit_addr_q <= DCS_UNIT_ADDR_RST;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (wr_evt & wdata_q[DCS_EVT_DEV_END] & (origin_q == i))
					de_pend_q[i] <= 1'b1;
				else if (wr_evt & wdata_q[DCS_EVT_CLR_DE_A + i])
					de_pend_q[i] <= 1'b0;
			end
			if (cmd_rr & chained)
				rej_q <= 1'b1;
			else if (wr_evt & wdata_q[DCS_EVT_CLR_REJ])
				rej_q <= 1'b0;
			if (cmd_rr & ~chained)
				sense_cnt_q <= sense_cnt_q + 8'h01;
			if (wr_ctrl)
				unit_addr_q <= wdata_q[7:0];
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite slave: address and data are taken together
	// ---------------------------------------------------------------
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			awready_q <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= DCS_RESP_OKAY;
			waddr_q   <= 8'h00;
			wdata_q   <= 32'h00000000;
			wstrb_q   <= 4'h0;
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rresp_q   <= DCS_RESP_OKAY;
			rdata_q   <= 32'h00000000;
		end else begin
			awready_q <= wr_go;
			if (wr_go) begin
				waddr_q <= S_AXI_AWADDR;
				wdata_q <= S_AXI_WDATA;
				wstrb_q <= S_AXI_WSTRB;
			end
			if (awready_q) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_map ? DCS_RESP_OKAY : DCS_RESP_SLVERR;
			end else if (S_AXI_BREADY)
				bvalid_q <= 1'b0;
			arready_q <= rd_go;
			if (rd_go) begin
				rdata_q <= rd_mux;
				rresp_q <= rd_map ? DCS_RESP_OKAY : DCS_RESP_SLVERR;
			end
			if (arready_q)
				rvalid_q <= 1'b1;
			else if (S_AXI_RREADY)
				rvalid_q <= 1'b0;
		end
	end

	assign S_AXI_AWREADY = awready_q;
	assign S_AXI_WREADY  = awready_q;
	assign S_AXI_BVALID  = bvalid_q;
	assign S_AXI_BRESP   = bresp_q;
	assign S_AXI_ARREADY = arready_q;
	assign S_AXI_RVALID  = rvalid_q;
	assign S_AXI_RRESP   = rresp_q;
	assign S_AXI_RDATA   = rdata_q;
	assign CHA_OP_IN     = op_in_q[0];
	assign CHB_OP_IN     = op_in_q[1];
	assign CHA_DRV_EN    = drv_q[0];
	assign CHB_DRV_EN    = drv_q[1];
	assign CHA_STATUS_IN = stin_q[0];
	assign CHB_STATUS_IN = stin_q[1];
	assign CHA_REQ_IN    = reqin_q[0];
	assign CHB_REQ_IN    = reqin_q[1];
	assign CHA_BUS_IN    = bus_in_q[0];
	assign CHB_BUS_IN    = bus_in_q[1];
	assign CHA_BUS_IN_P  = par_q[0];
	assign CHB_BUS_IN_P  = par_q[1];
	assign INIT_SEL      = init_q;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	a_owner_single: assert property (!(CHA_DRV_EN && CHB_DRV_EN) && !(CHA_OP_IN && CHB_OP_IN))
		else $error("switch owns both ports");
	a_busy_byte: assert property (busy_hit[0] |=> CHA_STATUS_IN && CHA_BUS_IN == 8'h50 && CHA_BUS_IN_P)
		else $error("short busy byte wrong on A");
	a_busy_no_conn: assert property (busy_hit[1] |=> !own[1] || resv_q)
		else $error("refused port B was connected");
	a_cue_latch: assert property (busy_hit[0] |=> cue_q[0])
		else $error("notice latch A not set on refusal");
	a_drv_qual: assert property (CHB_DRV_EN |-> own[1] && (CHB_OP_IN || CHB_REQ_IN))
		else $error("B drivers enabled without ownership");
	a_chain_reject: assert property (cmd_rr && chained && ~|reset_ok |=> rej_q && resv_q == $past(resv_q))
		else $error("chained reserve changed reservation");
	a_reserve_flag: assert property (cmd_rr && !chained && is_resv && ~|reset_ok |=>
		flags_q[5] && tags_q[5] && resv_q)
		else $error("reserve did not set flag and tag");
	a_release_tag: assert property (cmd_rr && !chained && !is_resv && ~|reset_ok |=> !tags_q[5] && !resv_q)
		else $error("release left tags-in position 2 set");
	a_foreign_reset: assert property (CHB_RESET && !CHA_RESET && own[0] && !end_chain &&
		!(resv_q && resv_ch_q) |=> !$fell(op_in_q[0]))
		else $error("foreign reset disturbed port A");
	a_cue_byte: assert property ($rose(CHA_REQ_IN) |-> CHA_BUS_IN == 8'h20)
		else $error("notice byte wrong on A");

	c_busy_a:   cover property (busy_hit[0]);
	c_cue_b:    cover property ($rose(CHB_REQ_IN));
	c_tie:      cover property (neutral && claim == 2'b11 && select == 2'b11);
	c_reserve:  cover property (cmd_rr && !chained && is_resv);
endmodule : dcs_switch

/* verif/dcs_chan_model.sv */
// Behavioural host channel: presents selections, resets and accepts request-in status.
// Assumes the switch samples every channel tag on the rising edge of CLK.
`timescale 1ns/1ps
module dcs_chan_model #(
	parameter int ACK_WAIT = 0
) (
	input  wire logic       CLK,
	input  wire logic       REQ_IN,
	output logic      [7:0] BUS_OUT,
	output logic            ADDR_OUT,
	output logic            SELECT,
	output logic            RESET,
	output logic            STAT_ACK
);
	int wait_q;
	initial begin
		BUS_OUT  = 8'h00;
		ADDR_OUT = 1'b0;
		SELECT   = 1'b0;
		RESET    = 1'b0;
		STAT_ACK = 1'b0;
		wait_q   = 0;
	end
	// Released bus shows the inverse, never a stale address
	task automatic sel(input logic [7:0] a);
		@(posedge CLK);
		BUS_OUT  <= a;
		ADDR_OUT <= 1'b1;
		SELECT   <= 1'b1;
		repeat (2) @(posedge CLK);
		ADDR_OUT <= 1'b0;
		BUS_OUT  <= ~a;
	endtask : sel
	task automatic drop();
		@(posedge CLK);
		SELECT <= 1'b0;
	endtask : drop
	task automatic rst_p();
		@(posedge CLK);
		RESET <= 1'b1;
		@(posedge CLK);
		RESET <= 1'b0;
	endtask : rst_p
	// Slow channels let request-in stand a few cycles before taking the byte
	always @(posedge CLK) begin
		if (REQ_IN && !STAT_ACK && wait_q >= ACK_WAIT) begin
			STAT_ACK <= 1'b1;
			wait_q   <= 0;
		end else begin
			STAT_ACK <= 1'b0;
			wait_q   <= REQ_IN ? wait_q + 1 : 0;
		end
	end
endmodule : dcs_chan_model

/* verif/tb.sv */
// Self-checking bench for the dual-channel switch: register bus tasks plus two channel models.
// Assumes the switch answers within a few cycles; a cycle ceiling cuts any hang.
`timescale 1ns/1ps
module tb;
	import dcs_pkg::*;
	logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	logic [7:0] awa = 0, ara = 0, a_bo, b_bo, a_bi, b_bi;
	logic [8:0] ab, bb;
	logic [3:0] ws = 4'hf;
	logic [31:0] wd = 0, rd, st;
	logic [1:0] rsp;
	logic a_ao, a_se, a_rs, a_ak, b_ao, b_se, b_rs, b_ak, a_op, a_de, a_si, a_rq, b_op, b_de, b_si, b_rq;
	logic awr, wr, bv, arr, rv, isel, bseen = 0, iseen = 0, aseen = 0, a_bp, b_bp;
	logic [1:0] brs, rrs;
	int n_errors = 0, compares = 0, cyc = 0, i;
	dcs_switch dut (.CLK(clk), .RST(rst), .CHA_BUS_OUT(a_bo), .CHA_ADDR_OUT(a_ao), .CHA_SELECT(a_se),
		.CHA_RESET(a_rs), .CHA_STAT_ACK(a_ak), .CHB_BUS_OUT(b_bo), .CHB_ADDR_OUT(b_ao), .CHB_SELECT(b_se),
		.CHB_RESET(b_rs), .CHB_STAT_ACK(b_ak), .CHA_OP_IN(a_op), .CHA_DRV_EN(a_de), .CHA_STATUS_IN(a_si),
		.CHA_REQ_IN(a_rq), .CHA_BUS_IN(a_bi), .CHA_BUS_IN_P(a_bp), .CHB_OP_IN(b_op), .CHB_DRV_EN(b_de),
		.CHB_STATUS_IN(b_si), .CHB_REQ_IN(b_rq), .CHB_BUS_IN(b_bi), .CHB_BUS_IN_P(b_bp), .INIT_SEL(isel),
		.S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
		.S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(brs), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rrs),
		.S_AXI_RVALID(rv), .S_AXI_RREADY(rre));
	dcs_chan_model #(.ACK_WAIT(0)) cha (.CLK(clk), .REQ_IN(a_rq), .BUS_OUT(a_bo), .ADDR_OUT(a_ao),
		.SELECT(a_se), .RESET(a_rs), .STAT_ACK(a_ak));
	dcs_chan_model #(.ACK_WAIT(3)) chb (.CLK(clk), .REQ_IN(b_rq), .BUS_OUT(b_bo), .ADDR_OUT(b_ao),
		.SELECT(b_se), .RESET(b_rs), .STAT_ACK(b_ak));
	initial begin
		forever #20 clk = ~clk;
	end
	// Short busy is a one-cycle pulse, so it is caught here
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (b_si) begin
			bseen <= 1'b1;
			bb    <= {b_bp, b_bi};
		end
		if (a_si) begin
			aseen <= 1'b1;
			ab    <= {a_bp, a_bi};
		end
		if (isel) iseen <= 1'b1;
		if (cyc == 20000) begin
			n_errors++;
			summarize();
		end
	end
	// ---------------------------------------------------------------
	// Register bus and comparison tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		awa <= a;
		wd  <= d;
		awv <= 1'b1;
		wv  <= 1'b1;
		bre <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (!bv);
		bre <= 1'b0;
		rsp = brs;
		@(posedge clk);
	endtask : axw
	task automatic axr(input logic [7:0] a);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (!rv);
		rre <= 1'b0;
		rsp = rrs;
		st  = rd;
		@(posedge clk);
	endtask : axr
	task automatic summarize();
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		axr(DCS_OFF_EVT);
		chk(st[2:0], 3'b001);
		axw(DCS_OFF_CTRL, 32'h0000_0035);
		axr(8'h40);
		chk(rsp, DCS_RESP_SLVERR);
		ws <= 4'h0;
		axw(DCS_OFF_CTRL, 32'h0000_0077);
		chk(rsp, DCS_RESP_OKAY);
		ws <= 4'hf;
		axr(DCS_OFF_CTRL);
		chk(st, 32'h0000_0035);
		chb.sel(8'h36);
		repeat (6) @(posedge clk);
		chk(b_op, 1'b0);
		chb.drop();
		cha.sel(8'h35);
		for (i = 0; i < 20 && !a_op; i++) @(posedge clk);
		@(posedge clk);
		chk({a_op, a_de, iseen}, 3'b111);
		$display("test select done");
		chb.sel(8'h35);
		for (i = 0; i < 20 && !bseen; i++) @(posedge clk);
		chk({bseen, bb, b_op}, {1'b1, 1'b1, DCS_STAT_BUSY, 1'b0});
		chb.drop();
		axw(DCS_OFF_CMD, {24'h0, DCS_CMD_RESERVE});
		axw(DCS_OFF_EVT, 32'h0000_0004);
		axr(DCS_OFF_FLAGS);
		chk(st, {24'h0, DCS_RESV_FLAG});
		axr(DCS_OFF_TAGS);
		chk(st, {24'h0, DCS_TAGS_HOLD});
		axr(DCS_OFF_SENSE);
		chk(st, 32'h1);
		chb.rst_p();
		axr(DCS_OFF_EVT);
		chk({st[12:5], st[2:0]}, 11'b0001_0110_010);
		cha.drop();
		axw(DCS_OFF_EVT, 32'h0000_0001);
		repeat (6) @(posedge clk);
		axr(DCS_OFF_EVT);
		chk({st[9], st[2:0]}, 4'b1010);
		$display("test reserve done");
		cha.sel(8'h35);
		for (i = 0; i < 20 && !a_op; i++) @(posedge clk);
		axw(DCS_OFF_CMD, 32'h0000_01d4);
		axr(DCS_OFF_EVT);
		chk({st[12], st[9]}, 2'b11);
		axw(DCS_OFF_CMD, {24'h0, DCS_CMD_RELEASE});
		axr(DCS_OFF_TAGS);
		chk(st, 32'h0);
		cha.drop();
		axw(DCS_OFF_EVT, 32'h0000_0001);
		for (i = 0; i < 40 && !b_rq; i++) @(posedge clk);
		chk({b_rq, b_bi}, {1'b1, DCS_STAT_CUE});
		for (i = 0; i < 40 && b_rq; i++) @(posedge clk);
		axw(DCS_OFF_EVT, 32'h0000_0001);
		chb.drop();
		repeat (6) @(posedge clk);
		axr(DCS_OFF_EVT);
		chk({st[9], st[6:5], st[2:0]}, 6'b000001);
		$display("test release done");
		bseen <= 1'b0;
		fork
			cha.sel(8'h35);
			chb.sel(8'h35);
		join
		for (i = 0; i < 20 && !bseen; i++) @(posedge clk);
		chk({a_op, b_op, bseen}, 3'b100);
		$display("test tie done");
		cha.drop();
		cha.rst_p();
		for (i = 0; i < 20 && !b_op; i++) @(posedge clk);
		chk({a_op, b_op, b_de}, 3'b011);
		$display("test reset done");
		cha.sel(8'h35);
		for (i = 0; i < 20 && !aseen; i++) @(posedge clk);
		chk({aseen, ab, a_op}, {1'b1, 1'b1, DCS_STAT_BUSY, 1'b0});
		chb.drop();
		axw(DCS_OFF_EVT, 32'h0000_0001);
		cha.drop();
		for (i = 0; i < 40 && !a_rq; i++) @(posedge clk);
		chk({a_rq, a_bi}, {1'b1, DCS_STAT_CUE});
		$display("test handover done");
		cha.sel(8'h35);
		for (i = 0; i < 20 && !a_op; i++) @(posedge clk);
		cha.drop();
		axw(DCS_OFF_EVT, 32'h0000_0002);
		axw(DCS_OFF_EVT, 32'h0000_0001);
		repeat (4) @(posedge clk);
		axr(DCS_OFF_EVT);
		chk({a_op, st[11], st[2:0]}, 5'b01010);
		$display("test stack done");
		summarize();
	end
endmodule : tb
